// [core/alarm_params.svh]
// register offsets, field positions, reset values and type codes of the alarm evaluator
// assumes a 32-bit AHB-Lite bus with one word per register
`ifndef ALARM_PARAMS_SVH
`define ALARM_PARAMS_SVH

`define OFF_CTRL        8'h00
`define OFF_TYPE        8'h04
`define OFF_STATUS      8'h08
`define OFF_MASK        8'h0c
`define OFF_ALARM       8'h10
`define CHAN_BASE_NIB   4'h2
`define SUB_UPPER       4'h0
`define SUB_LOWER       4'h4
`define SUB_HYST        4'h8
`define CTRL_RESTART    3
`define TYPE_RESET      4'h2
`define HYST_RESET      16'h0002

`define CODE_OFF        4'h0
`define CODE_RANGE_OUT  4'h1
`define CODE_DEV_HI     4'h2
`define CODE_DEV_LO     4'h3
`define CODE_RANGE_IN   4'h4
`define CODE_RANGE_SB   4'h5
`define CODE_DEV_HI_SB  4'h6
`define CODE_DEV_LO_SB  4'h7
`define CODE_ABS_HI     4'h8
`define CODE_ABS_LO     4'h9
`define CODE_ABS_HI_SB  4'ha
`define CODE_ABS_LO_SB  4'hb
`define CODE_LOOP_BREAK 4'hc
`define CODE_RATE       4'hd
`define CODE_RSP_HI     4'he
`define CODE_RSP_LO     4'hf

`endif

// [core/alarm_pkg.sv]
// types shared by the alarm evaluator
// assumes alarm_params.svh supplies the numeric constants
package alarm_pkg;
    typedef logic [3:0] type_code_t;
    typedef logic [1:0] htrans_t;
endpackage : alarm_pkg

// [core/process_alarm_type_evaluator.sv]
// three-channel process alarm evaluator with an AHB-Lite register slave
// assumes process value and set points are synchronous signed samples on CORE_CLK
//
// How it works
// - a channel's type is writable only while that channel is assigned
// - channel one offers deviation, range, absolute, loop-break, rate and remote alarms
// - codes 1, 4, 5 use independent upper and lower thresholds
// - code 5 drops its lower part when hysteresis bands overlap
// - code 5 with lower above upper keeps the alarm off
// - codes 14 and 15 are refused unless the remote set point exists
// - each channel has its own type code, resetting to 2
// - codes 10 and 11 are absolute high and low with standby
// - code 14 alarms when remote set point exceeds the upper value
// - code 15 alarms when remote set point is below the lower value
// - code 13 follows the external rate-of-change detector
// - channels two and three refuse the loop-break code 12
// - hysteresis only applies to assigned channels with code not 0, 12, 13
`timescale 1ns/1ns
`include "alarm_params.svh"

module process_alarm_type_evaluator #(
    parameter int DW            = 16,
    parameter bit HAS_REMOTE_SP = 1'b1
) (
    input  wire logic                 CORE_CLK,
    input  wire logic                 RST,
    input  wire logic                 HSEL,
    input  wire logic [31:0]          HADDR,
    input  wire alarm_pkg::htrans_t   HTRANS,
    input  wire logic                 HWRITE,
    input  wire logic [2:0]           HSIZE,
    input  wire logic [31:0]          HWDATA,
    input  wire logic                 HREADY,
    output logic                      HREADYOUT,
    output logic                      HRESP,
    output logic [31:0]               HRDATA,
    input  wire logic signed [DW-1:0] PROCESS_VALUE,
    input  wire logic signed [DW-1:0] SET_POINT,
    input  wire logic signed [DW-1:0] REMOTE_SETPOINT,
    input  wire logic                 LOOP_BREAK_DET,
    input  wire logic [2:0]           RATE_DET,
    output logic [2:0]                ALARM_OUT,
    output logic                      IRQ
);

    typedef logic signed [DW+1:0] wide_t;
    typedef struct packed {
        logic [2:0]                      assigned;
        logic [2:0][3:0]                 tcode;
        logic [2:0][DW-1:0]              upper;
        logic [2:0][DW-1:0]              lower;
        logic [2:0][DW-1:0]              hyst;
        logic [2:0]                      hi;
        logic [2:0]                      lo;
        logic [2:0]                      standby;
        logic [2:0]                      alarm;
        logic [2:0]                      status;
        logic [2:0]                      mask;
        logic                            dwrite;
        logic [7:0]                      daddr;
        logic [31:0]                     rdata;
    } state_s;

    state_s s_reg;
    state_s s_next;
    function automatic wide_t sx(input logic [DW-1:0] x);
        sx = wide_t'(signed'(x));
    endfunction : sx
    function automatic logic legal(input int ch, input logic [3:0] code);
        legal = 1'b1;
        // no loop break on two, three
        if (ch != 0 && code == `CODE_LOOP_BREAK) begin
            legal = 1'b0;
        end
        if (!HAS_REMOTE_SP && (code == `CODE_RSP_HI || code == `CODE_RSP_LO)) begin
            legal = 1'b0;
        end
    endfunction : legal
    function automatic logic is_standby(input logic [3:0] code);
        is_standby = code == `CODE_RANGE_SB || code == `CODE_DEV_HI_SB || code == `CODE_DEV_LO_SB
                  || code == `CODE_ABS_HI_SB || code == `CODE_ABS_LO_SB;
    endfunction : is_standby

    // ------------------------------------------------------------------
    // bus and alarm evaluation
    // ------------------------------------------------------------------
    always_comb begin
        logic        accept;
        logic [7:0]  ra;
        logic [3:0]  code;
        logic [3:0]  base;
        wide_t       v;
        wide_t       h;
        wide_t       l;
        wide_t       hy;
        logic        strict;
        logic        up_set;
        logic        up_hold;
        logic        lo_set;
        logic        lo_hold;
        logic        raw;
        logic [2:0]  w1c;
        logic [2:0]  rise;
        code    = 4'h0;
        base    = 4'h0;
        v       = '0;
        h       = '0;
        l       = '0;
        hy      = '0;
        strict  = 1'b0;
        up_set  = 1'b0;
        up_hold = 1'b0;
        lo_set  = 1'b0;
        lo_hold = 1'b0;
        raw     = 1'b0;
        w1c     = 3'h0;
        rise    = 3'h0;
        s_next  = s_reg;
        accept         = HSEL && HREADY && HTRANS[1];
        ra             = HADDR[7:0];
        s_next.dwrite  = accept && HWRITE;
        s_next.daddr   = ra;
        s_next.rdata   = 32'h0000_0000;
        if (accept && !HWRITE) begin
            if (ra == `OFF_CTRL) begin
                s_next.rdata = {29'h0, s_reg.assigned};
            end else if (ra == `OFF_TYPE) begin
                s_next.rdata = {20'h0, s_reg.tcode};
            end else if (ra == `OFF_STATUS) begin
                s_next.rdata = {29'h0, s_reg.status};
            end else if (ra == `OFF_MASK) begin
                s_next.rdata = {29'h0, s_reg.mask};
            end else if (ra == `OFF_ALARM) begin
                s_next.rdata = {29'h0, s_reg.alarm};
            end else if (ra[7:4] >= `CHAN_BASE_NIB && ra[7:4] < `CHAN_BASE_NIB + 4'h3) begin
                if (ra[3:0] == `SUB_UPPER) begin
                    s_next.rdata = 32'(s_reg.upper[2'(ra[7:4] - `CHAN_BASE_NIB)]);
                end else if (ra[3:0] == `SUB_LOWER) begin
                    s_next.rdata = 32'(s_reg.lower[2'(ra[7:4] - `CHAN_BASE_NIB)]);
                end else if (ra[3:0] == `SUB_HYST) begin
                    s_next.rdata = 32'(s_reg.hyst[2'(ra[7:4] - `CHAN_BASE_NIB)]);
                end
            end
        end
        if (s_reg.dwrite) begin
            if (s_reg.daddr == `OFF_CTRL) begin
                s_next.assigned = HWDATA[2:0];
                if (HWDATA[`CTRL_RESTART]) begin
                    s_next.standby = 3'h7;
                end
            end else if (s_reg.daddr == `OFF_TYPE) begin
                for (int c = 0; c < 3; c++) begin
                    if (s_reg.assigned[c] && legal(c, HWDATA[4*c +: 4])) begin
                        s_next.tcode[c] = HWDATA[4*c +: 4];
                        if (HWDATA[4*c +: 4] != s_reg.tcode[c]) begin
                            s_next.standby[c] = 1'b1;
                        end
                    end
                end
            end else if (s_reg.daddr == `OFF_STATUS) begin
                w1c = HWDATA[2:0];
            end else if (s_reg.daddr == `OFF_MASK) begin
                s_next.mask = HWDATA[2:0];
            end else if (s_reg.daddr[7:4] >= `CHAN_BASE_NIB && s_reg.daddr[7:4] < `CHAN_BASE_NIB + 4'h3) begin
                if (s_reg.daddr[3:0] == `SUB_UPPER) begin
                    s_next.upper[2'(s_reg.daddr[7:4] - `CHAN_BASE_NIB)] = HWDATA[DW-1:0];
                end else if (s_reg.daddr[3:0] == `SUB_LOWER) begin
                    s_next.lower[2'(s_reg.daddr[7:4] - `CHAN_BASE_NIB)] = HWDATA[DW-1:0];
                end else if (s_reg.daddr[3:0] == `SUB_HYST) begin
                    s_next.hyst[2'(s_reg.daddr[7:4] - `CHAN_BASE_NIB)] = HWDATA[DW-1:0];
                end
            end
        end
        for (int c = 0; c < 3; c++) begin
            code = s_reg.tcode[c];
            h    = sx(s_reg.upper[c]);
            l    = sx(s_reg.lower[c]);
            hy   = (code == `CODE_OFF || code == `CODE_LOOP_BREAK || code == `CODE_RATE)
                   ? wide_t'(0) : wide_t'({2'b00, s_reg.hyst[c]});
            unique case (code)
                `CODE_RANGE_SB:  base = `CODE_RANGE_OUT;
                `CODE_DEV_HI_SB: base = `CODE_DEV_HI;
                `CODE_DEV_LO_SB: base = `CODE_DEV_LO;
                `CODE_ABS_HI_SB: base = `CODE_ABS_HI;
                `CODE_ABS_LO_SB: base = `CODE_ABS_LO;
                default:         base = code;
            endcase
            if (base <= `CODE_RANGE_IN) begin
                v = sx(PROCESS_VALUE) - sx(SET_POINT);
            end else if (base >= `CODE_RSP_HI) begin
                v = sx(REMOTE_SETPOINT);
            end else begin
                v = sx(PROCESS_VALUE);
            end
            strict  = base >= `CODE_ABS_HI;
            up_set  = strict ? (v > h) : (v >= h);
            up_hold = v >= h - hy;
            lo_set  = strict ? (v < l) : (v <= l);
            lo_hold = v <= l + hy;
            s_next.hi[c] = 1'b0;
            s_next.lo[c] = 1'b0;
            unique case (base)
                `CODE_RANGE_OUT: begin
                    s_next.hi[c] = up_set || (s_reg.hi[c] && up_hold);
                    s_next.lo[c] = lo_set || (s_reg.lo[c] && lo_hold);
                end
                `CODE_DEV_HI, `CODE_ABS_HI, `CODE_RSP_HI: begin
                    s_next.hi[c] = up_set || (s_reg.hi[c] && up_hold);
                end
                `CODE_DEV_LO, `CODE_ABS_LO, `CODE_RSP_LO: begin
                    s_next.lo[c] = lo_set || (s_reg.lo[c] && lo_hold);
                end
                `CODE_RANGE_IN: begin
                    s_next.hi[c] = (v >= l && v <= h) || (s_reg.hi[c] && v >= l - hy && v <= h + hy);
                end
                `CODE_LOOP_BREAK: begin
                    s_next.hi[c] = (c == 0) && LOOP_BREAK_DET;
                end
                `CODE_RATE: begin
                    s_next.hi[c] = RATE_DET[c];
                end
                default: begin
                end
            endcase
            if (code == `CODE_RANGE_SB) begin
                if (l > h) begin
                    s_next.hi[c] = 1'b0;
                    s_next.lo[c] = 1'b0;
                end else if (h - hy <= l + hy) begin
                    s_next.lo[c] = 1'b0;
                end
            end
            if (!s_reg.assigned[c]) begin
                s_next.hi[c] = 1'b0;
                s_next.lo[c] = 1'b0;
            end
            raw = s_next.hi[c] || s_next.lo[c];
            s_next.alarm[c] = raw && !(is_standby(code) && s_reg.standby[c]);
            if (is_standby(code) && s_reg.standby[c] && !raw) begin
                s_next.standby[c] = 1'b0;
            end
        end
        rise          = s_next.alarm & ~s_reg.alarm;
        s_next.status = (s_reg.status & ~w1c) | rise;
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            s_reg          <= '0;
            s_reg.tcode    <= {3{`TYPE_RESET}};
            s_reg.hyst     <= {3{DW'(`HYST_RESET)}};
            s_reg.standby  <= 3'h7;
        end else begin
            s_reg <= s_next;
        end
    end

    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign HRDATA    = s_reg.rdata;
    assign ALARM_OUT = s_reg.alarm;
    assign IRQ       = |(s_reg.status & s_reg.mask);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    wide_t dev_a;
    assign dev_a = sx(PROCESS_VALUE) - sx(SET_POINT);
    sequence s_rise0;
        $rose(ALARM_OUT[0]);
    endsequence
    property p_irq_on_rise;
        s_rise0 ##0 s_reg.mask[0] |-> IRQ;
    endproperty
    a_irq_on_rise: assert property (p_irq_on_rise) else $error("masked-in alarm rise gave no interrupt");
    property p_unassigned_quiet;
        !s_reg.assigned[0] |=> !ALARM_OUT[0];
    endproperty
    a_unassigned_quiet: assert property (p_unassigned_quiet) else $error("unassigned channel alarmed");
    property p_off_quiet;
        s_reg.tcode[0] == `CODE_OFF |=> !ALARM_OUT[0];
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("type 0 alarmed");
    property p_no_lbreak;
        s_reg.tcode[1] != `CODE_LOOP_BREAK && s_reg.tcode[2] != `CODE_LOOP_BREAK;
    endproperty
    a_no_lbreak: assert property (p_no_lbreak) else $error("loop break on channel two or three");
    property p_rsp_gate;
        !HAS_REMOTE_SP |-> s_reg.tcode[0] < `CODE_RSP_HI;
    endproperty
    a_rsp_gate: assert property (p_rsp_gate) else $error("remote type without remote input");
    property p_empty_window;
        s_reg.tcode[0] == `CODE_RANGE_SB && sx(s_reg.lower[0]) > sx(s_reg.upper[0]) |=> !ALARM_OUT[0];
    endproperty
    a_empty_window: assert property (p_empty_window) else $error("code 5 empty window alarmed");
    property p_dev_high;
        s_reg.assigned[0] && s_reg.tcode[0] == `CODE_DEV_HI && dev_a >= sx(s_reg.upper[0]) |=> ALARM_OUT[0];
    endproperty
    a_dev_high: assert property (p_dev_high) else $error("upper deviation missed");
    property p_rsp_high;
        s_reg.assigned[0] && s_reg.tcode[0] == `CODE_RSP_HI && sx(REMOTE_SETPOINT) > sx(s_reg.upper[0])
            |=> ALARM_OUT[0];
    endproperty
    a_rsp_high: assert property (p_rsp_high) else $error("remote high missed");
    property p_rsp_low;
        s_reg.assigned[0] && s_reg.tcode[0] == `CODE_RSP_LO && sx(REMOTE_SETPOINT) < sx(s_reg.lower[0])
            |=> ALARM_OUT[0];
    endproperty
    a_rsp_low: assert property (p_rsp_low) else $error("remote low missed");
    property p_rate;
        s_reg.assigned[0] && s_reg.tcode[0] == `CODE_RATE && RATE_DET[0] |=> ALARM_OUT[0];
    endproperty
    a_rate: assert property (p_rate) else $error("rate alarm missed");
    property p_standby_quiet;
        s_reg.standby[0] && is_standby(s_reg.tcode[0]) |=> !ALARM_OUT[0];
    endproperty
    a_standby_quiet: assert property (p_standby_quiet) else $error("alarm during standby");

endmodule : process_alarm_type_evaluator

// [dv/proc_source.sv]
// ----------------------------------------
// process-side partner: plant values and detector levels
// ----------------------------------------
// assumes the bench changes requests just after a rising edge
`timescale 1ns/1ns

module proc_source (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic signed [15:0] pv_req,
    input  wire logic signed [15:0] sp_req,
    input  wire logic signed [15:0] rsetp_req,
    input  wire logic               lb_req,
    input  wire logic [2:0]         rate_req,
    output logic signed [15:0]      pv,
    output logic signed [15:0]      sp,
    output logic signed [15:0]      rsetp,
    output logic                    lb,
    output logic [2:0]              rate
);
    // a sampling front end: values reach the evaluator one edge late
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {pv, sp, rsetp, lb, rate} <= '0;
        end else begin
            {pv, sp, rsetp, lb, rate} <= {pv_req, sp_req, rsetp_req, lb_req, rate_req};
        end
    end
endmodule : proc_source

// [dv/process_alarm_type_evaluator_test.sv]
// ----------------------------------------
// self-checking bench of the alarm evaluator
// ----------------------------------------
// assumes one AHB-Lite slave whose hreadyout is the bus hready, and registered alarm outputs
`timescale 1ns/1ns
`include "alarm_params.svh"

module process_alarm_type_evaluator_test;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic               hsel = 1'b0;
    logic               hwrite = 1'b0;
    logic [31:0]        haddr = '0;
    logic [31:0]        hwdata = '0;
    alarm_pkg::htrans_t htrans = 2'h0;
    logic               hreadyout, hresp, irq, lb, lb_req = 1'b0;
    logic [31:0]        hrdata, rd;
    logic signed [15:0] pv_req = '0, sp_req = '0, rsetp_req = '0, pv, sp, rsetp;
    logic [2:0]         rate_req = '0, rate, alarm;
    logic [31:0]        seed = 32'ha773;
    int                 bad_count = 0;
    int                 checks_done = 0;
    int                 codes[11] = '{0, 1, 2, 3, 4, 8, 9, 12, 13, 14, 15};

    always #2 clk = ~clk;

    proc_source proc_source_inst (.clk(clk), .rst(rst), .pv_req(pv_req), .sp_req(sp_req),
        .rsetp_req(rsetp_req), .lb_req(lb_req), .rate_req(rate_req), .pv(pv), .sp(sp),
        .rsetp(rsetp), .lb(lb), .rate(rate));

    process_alarm_type_evaluator process_alarm_type_evaluator_inst (.CORE_CLK(clk), .RST(rst),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
        .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRESP(hresp),
        .HRDATA(hrdata), .PROCESS_VALUE(pv), .SET_POINT(sp), .REMOTE_SETPOINT(rsetp),
        .LOOP_BREAK_DET(lb), .RATE_DET(rate), .ALARM_OUT(alarm), .IRQ(irq));

    // ----------------------------------------
    // reference model and helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function automatic bit model(int c, int p, int s, int r, int h, int l, bit b, bit t);
        int d;
        d = p - s;
        case (c)
            1: return d >= h || d <= l;
            2: return d >= h;
            3: return d <= l;
            4: return d >= l && d <= h;
            8: return p > h;
            9: return p < l;
            12: return b;
            13: return t;
            14: return r > h;
            15: return r < l;
            default: return 1'b0;
        endcase
    endfunction : model

    function automatic logic [31:0] chan(int c, logic [3:0] sub);
        return {24'h0, `CHAN_BASE_NIB + 4'(c), sub};
    endfunction : chan

    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        // no wait count assumed: only the watchdog ends a stalled transfer
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic cmp_word(logic [31:0] got, logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t register got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_bit(logic got, logic exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t output got %b expected %b", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic rdc(logic [31:0] a, logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        cmp_bit(hresp, 1'b0);
        cmp_word(rd, exp);
    endtask : rdc

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        tick(12);
        rst <= 1'b0;
        tick(1);
        rdc(`OFF_TYPE, 32'h222);
        rdc(chan(1, `SUB_HYST), 32'h2);
        rdc(32'hfc, 32'h0);
        bus(1'b1, `OFF_TYPE, 32'h0);
        rdc(`OFF_TYPE, 32'h222);
        bus(1'b1, `OFF_CTRL, 32'h7);
        bus(1'b1, `OFF_TYPE, 32'hccc);
        rdc(`OFF_TYPE, 32'h22c);
        bus(1'b1, `OFF_TYPE, 32'h2fe);
        rdc(`OFF_TYPE, 32'h2fe);
        bus(1'b1, chan(0, `SUB_UPPER), 32'd20);
        bus(1'b1, chan(0, `SUB_LOWER), 32'hffec);
        bus(1'b1, chan(0, `SUB_HYST), 32'h0);
        // every non-standby code against the model
        for (int i = 0; i < 44; i++) begin
            bus(1'b1, `OFF_TYPE, 32'h2f0 | codes[i % 11]);
            seed = lfsr(seed);
            // odd levels never sit on +-20, where the strict types would hold over
            pv_req <= (16'($signed({1'b0, seed[6:0]})) - 16'sd64) | 16'sd1;
            sp_req <= 16'($signed({1'b0, seed[11:8]})) - 16'sd8;
            rsetp_req <= (16'($signed({1'b0, seed[20:14]})) - 16'sd64) | 16'sd1;
            lb_req <= seed[22];
            rate_req <= seed[25:23];
            tick(4);
            cmp_bit(alarm[0], model(codes[i % 11], pv_req, sp_req, rsetp_req,
                20, -20, lb_req, rate_req[0]));
        end
        sp_req <= 16'sd0;
        // standby suppresses until the region is left once
        foreach (codes[k]) if (k < 2) begin
            pv_req <= 16'sd30;
            tick(3);
            bus(1'b1, `OFF_TYPE, k ? 32'h2fa : 32'h2f6);
            tick(3);
            cmp_bit(alarm[0], 1'b0);
            pv_req <= 16'sd0;
            tick(4);
            pv_req <= 16'sd30;
            tick(4);
            cmp_bit(alarm[0], 1'b1);
        end
        // hysteresis holds the alarm until upper minus band
        bus(1'b1, chan(0, `SUB_HYST), 32'h4);
        bus(1'b1, `OFF_TYPE, 32'h2f2);
        pv_req <= 16'sd20;
        tick(4);
        cmp_bit(alarm[0], 1'b1);
        pv_req <= 16'sd17;
        tick(4);
        cmp_bit(alarm[0], 1'b1);
        pv_req <= 16'sd15;
        tick(4);
        cmp_bit(alarm[0], 1'b0);
        // lower above upper: code 1 always on, code 5 always off
        bus(1'b1, chan(0, `SUB_UPPER), 32'hfff6);
        bus(1'b1, chan(0, `SUB_LOWER), 32'h000a);
        for (int c = 0; c < 2; c++) begin
            bus(1'b1, `OFF_TYPE, c ? 32'h2f5 : 32'h2f1);
            for (int p = -30; p <= 30; p += 30) begin
                pv_req <= 16'(p);
                tick(4);
                cmp_bit(alarm[0], c == 0);
            end
        end
        // overlapping bands: code 5 keeps its upper part and drops its lower part
        bus(1'b1, chan(0, `SUB_UPPER), 32'h0002);
        bus(1'b1, chan(0, `SUB_LOWER), 32'hfffe);
        pv_req <= 16'hfff6;
        tick(4);
        cmp_bit(alarm[0], 1'b0);
        pv_req <= 16'h000a;
        tick(4);
        cmp_bit(alarm[0], 1'b1);
        // interrupt: raise, acknowledge, mask
        bus(1'b1, chan(0, `SUB_UPPER), 32'd20);
        bus(1'b1, `OFF_TYPE, 32'h2f8);
        pv_req <= 16'sd0;
        tick(4);
        bus(1'b1, `OFF_STATUS, 32'h7);
        bus(1'b1, `OFF_MASK, 32'h1);
        tick(1);
        cmp_bit(irq, 1'b0);
        pv_req <= 16'sd30;
        tick(4);
        cmp_bit(irq, 1'b1);
        bus(1'b0, `OFF_STATUS, 32'h0);
        cmp_word(rd & 32'h1, 32'h1);
        bus(1'b1, `OFF_STATUS, 32'h1);
        tick(1);
        cmp_bit(irq, 1'b0);
        bus(1'b1, `OFF_MASK, 32'h0);
        pv_req <= 16'sd0;
        tick(4);
        pv_req <= 16'sd30;
        tick(4);
        cmp_bit(irq, 1'b0);
        bus(1'b1, `OFF_MASK, 32'h1);
        tick(1);
        cmp_bit(irq, 1'b1);
        // channel three still runs its reset type against a zero upper value
        cmp_bit(alarm[2], 1'b1);
        bus(1'b0, `OFF_ALARM, 32'h0);
        cmp_word(rd & 32'h5, 32'h5);
        tally_and_finish();
    end

    // the whole sequence needs well under 5,000 cycles
    initial begin
        #80000;
        bad_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule : process_alarm_type_evaluator_test
